// file: verilog/gcw_pkg.sv
// Package with register map, field layout and reset values for group control.
package gcw_pkg;
  // ****************************************************
  // Register byte addresses.
  // ****************************************************
  localparam logic [7:0] ADDR_GROUP_CMD = 8'h00;
  localparam logic [7:0] ADDR_ALARM_IMG = 8'h04;
  localparam logic [7:0] ADDR_ALARM_ACK = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_EVENT_LOG = 8'h1C;
  // ****************************************************
  // Field positions and codes.
  // ****************************************************
  localparam int MASK_LSB = 0;
  localparam int CMD_LSB = 8;
  localparam int TRIG_BIT = 15;
  localparam logic [6:0] CMD_UNFREEZE = 7'h04;
  localparam logic [6:0] CMD_FREEZE = 7'h08;
  localparam logic [6:0] CMD_UNSYNC = 7'h10;
  localparam logic [6:0] CMD_SYNC = 7'h20;
  localparam int CFG_CLEAR_ON_LOSS = 0;
  localparam int CFG_FAULT_REPORT = 1;
  localparam int IRQ_SENT = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_STATION_EV = 2;
  localparam int IRQ_BAD_CMD = 3;
  localparam int NUM_IRQ = 4;
  localparam int NUM_STATIONS = 128;
  // ****************************************************
  // Reset values.
  // ****************************************************
  localparam logic [15:0] GROUP_CMD_RESET = 16'h0000;
  localparam logic [1:0] CONFIG_RESET = 2'h2;
  localparam logic [31:0] ALARM_IMG_RESET = 32'h0000_0000;
endpackage

// file: verilog/trig_edge.sv
// Toggle detector that turns any change of a level into a one-cycle pulse.
`timescale 1ns/1ns
module trig_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Level in, pulse out
  input wire logic level_i,
  output logic pulse_o
);
  logic last_level;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_level <= 1'b0;
    end else begin
      last_level <= level_i;
    end
  end

  assign pulse_o = level_i ^ last_level;
endmodule

// file: verilog/station_loss.sv
// Tracks one station's link state and emits loss and re-establish pulses.
`timescale 1ns/1ns
module station_loss (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link health, synchronised
  input wire logic alive_i,
  // Events
  output logic lost_o,
  output logic regained_o
);
  logic was_alive;

  // Starts as alive, matching the synchroniser's reset value, so that leaving
  // reset never looks like a re-established link.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      was_alive <= 1'b1;
    end else begin
      was_alive <= alive_i;
    end
  end

  assign lost_o = was_alive & ~alive_i;
  assign regained_o = ~was_alive & alive_i;
endmodule

// file: verilog/group_control.sv
// Group command word, alarm status image and station loss handling, on APB.
// Functional notes
// - Low byte of the command word is a group mask, bit n selects group n.
// - High byte holds command code: unfreeze 04, freeze 08, unsync 10, sync 20.
// - Every change of bit 15, rising or falling, sends the command once.
// - The command word is 16 bits and always has a fixed location.
// - At a scan start with no alarm outstanding (or one being serviced), the 32-bit alarm image gets a pending station address.
// - Only one alarm station is reported; others wait until it is serviced.
// - On station loss inputs hold last values by default, or read cleared.
// - With fault reporting enabled, loss and re-establish events are logged.
`timescale 1ns/1ns
module group_control
  import gcw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Global control command to the bus engine
  output logic send_o,
  output logic [7:0] send_groups_o,
  output logic [6:0] send_cmd_o,
  // Scan and alarm sources
  input wire logic scan_start_i,
  input wire logic [NUM_STATIONS-1:0] alarm_pend_i,
  input wire logic comm_request_i,
  input wire logic [7:0] comm_request_task_i,
  output logic [NUM_STATIONS-1:0] alarm_serviced_o,
  // Station health pins and input data policy
  input wire logic [NUM_STATIONS-1:0] station_alive_i,
  input wire logic [6:0] data_station_i,
  input wire logic [15:0] data_raw_i,
  output logic [15:0] data_o,
  // Interrupt
  output logic irq_o
);
  // ****************************************************
  // Register storage.
  // ****************************************************
  logic [15:0] group_command_word;
  logic [31:0] alarm_pending_image;
  logic [1:0] lost_station_input_policy;
  logic [NUM_IRQ-1:0] irq_status;
  logic [NUM_IRQ-1:0] irq_enable;
  logic [7:0] event_station;
  logic event_was_loss;
  logic alarm_busy;
  logic [6:0] alarm_station;
  logic [NUM_STATIONS-1:0] alive_s1;
  logic [NUM_STATIONS-1:0] alive_s2;
  logic [NUM_STATIONS-1:0] held_stations;

  // ****************************************************
  // Bus decode.
  // ****************************************************
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire wr_cmd = wr & (paddr == ADDR_GROUP_CMD);
  wire wr_ack = wr & (paddr == ADDR_ALARM_ACK);
  wire wr_cfg = wr & (paddr == ADDR_CONFIG);
  wire wr_ien = wr & (paddr == ADDR_IRQ_ENABLE);
  wire wr_clr = wr & (paddr == ADDR_IRQ_CLEAR);
  wire known = (paddr == ADDR_GROUP_CMD) | (paddr == ADDR_ALARM_IMG) |
               (paddr == ADDR_ALARM_ACK) | (paddr == ADDR_CONFIG) |
               (paddr == ADDR_IRQ_STATUS) | (paddr == ADDR_IRQ_ENABLE) |
               (paddr == ADDR_IRQ_CLEAR) | (paddr == ADDR_EVENT_LOG);
  assign pready = 1'b1;
  assign pslverr = access & ~known;

  // ****************************************************
  // Group command word and trigger.
  // ****************************************************
  wire [7:0] cmd_byte = group_command_word[15:CMD_LSB];
  wire [6:0] cmd_code = cmd_byte[6:0];
  wire trig_pulse;
  wire cmd_legal = (cmd_code == CMD_UNFREEZE) | (cmd_code == CMD_FREEZE) |
                   (cmd_code == CMD_UNSYNC) | (cmd_code == CMD_SYNC);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      group_command_word <= GROUP_CMD_RESET;
    end else if (wr_cmd) begin
      group_command_word <= pwdata[15:0];
    end
  end

  // Both edges of bit 15 count, so the detector flags any difference.
  trig_edge u_trig (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .level_i(group_command_word[TRIG_BIT]),
    .pulse_o(trig_pulse)
  );

  // Illegal codes are still sent; the bad-command flag lets software see it.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      send_o <= 1'b0;
      send_groups_o <= 8'h00;
      send_cmd_o <= 7'h00;
    end else begin
      send_o <= trig_pulse;
      if (trig_pulse) begin
        send_groups_o <= group_command_word[7:MASK_LSB];
        send_cmd_o <= cmd_code;
      end
    end
  end

  // ****************************************************
  // Alarm status image.
  // ****************************************************
  // The station being serviced still shows its alarm this cycle; leave it
  // out so that a scan start in the same cycle reports the next one.
  wire [NUM_STATIONS-1:0] pend_now = alarm_pend_i & ~alarm_serviced_o;
  logic [6:0] first_pend;
  logic any_pend;
  always_comb begin
    first_pend = 7'h00;
    any_pend = 1'b0;
    for (int i = NUM_STATIONS - 1; i >= 0; i--) begin
      if (pend_now[i]) begin
        first_pend = 7'(i);
        any_pend = 1'b1;
      end
    end
  end

  wire task9 = comm_request_i & (comm_request_task_i == 8'h09);
  wire service = alarm_busy & (task9 | wr_ack);
  wire load_alarm = scan_start_i & any_pend & (~alarm_busy | service);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_busy <= 1'b0;
      alarm_station <= 7'h00;
      alarm_pending_image <= ALARM_IMG_RESET;
    end else if (load_alarm) begin
      alarm_busy <= 1'b1;
      alarm_station <= first_pend;
      alarm_pending_image <= {25'h000_0000, first_pend};
    end else if (service) begin
      alarm_busy <= 1'b0;
      alarm_pending_image <= ALARM_IMG_RESET;
    end
  end

  always_comb begin
    alarm_serviced_o = '0;
    alarm_serviced_o[alarm_station] = service;
  end

  // ****************************************************
  // Station health, loss policy and event log.
  // ****************************************************
  // Links are taken as up out of reset, so no false events follow reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alive_s1 <= '1;
      alive_s2 <= '1;
    end else begin
      alive_s1 <= station_alive_i;
      alive_s2 <= alive_s1;
    end
  end

  wire [NUM_STATIONS-1:0] lost_ev;
  wire [NUM_STATIONS-1:0] back_ev;
  for (genvar s = 0; s < NUM_STATIONS; s++) begin : g_st
    station_loss u_st (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .alive_i(alive_s2[s]),
      .lost_o(lost_ev[s]),
      .regained_o(back_ev[s])
    );
  end

  logic [6:0] ev_idx;
  logic ev_any;
  always_comb begin
    ev_idx = 7'h00;
    ev_any = 1'b0;
    for (int i = NUM_STATIONS - 1; i >= 0; i--) begin
      if (lost_ev[i] | back_ev[i]) begin
        ev_idx = 7'(i);
        ev_any = 1'b1;
      end
    end
  end
  wire fault_on = lost_station_input_policy[CFG_FAULT_REPORT];
  wire log_ev = ev_any & fault_on;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lost_station_input_policy <= CONFIG_RESET;
      event_station <= 8'h00;
      event_was_loss <= 1'b0;
      held_stations <= '0;
    end else begin
      if (wr_cfg) begin
        lost_station_input_policy <= pwdata[1:0];
      end
      if (log_ev) begin
        event_station <= {1'b0, ev_idx};
        event_was_loss <= lost_ev[ev_idx];
      end
      held_stations <= ~alive_s2;
    end
  end

  wire clear_lost = lost_station_input_policy[CFG_CLEAR_ON_LOSS];
  wire station_down = held_stations[data_station_i];
  // Hold-last mode keeps data_o at its last value while the selected station is down.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= 16'h0000;
    end else if (station_down & clear_lost) begin
      data_o <= 16'h0000;
    end else if (!station_down) begin
      data_o <= data_raw_i;
    end
  end

  // ****************************************************
  // Interrupts: set wins over clear.
  // ****************************************************
  wire [NUM_IRQ-1:0] irq_set = {trig_pulse & ~cmd_legal, log_ev,
                                load_alarm, send_o};
  wire [NUM_IRQ-1:0] irq_clr = wr_clr ? pwdata[NUM_IRQ-1:0] : '0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_ien) begin
        irq_enable <= pwdata[NUM_IRQ-1:0];
      end
    end
  end
  assign irq_o = |(irq_status & irq_enable);

  // ****************************************************
  // Read data.
  // ****************************************************
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_GROUP_CMD: prdata = {16'h0000, group_command_word};
      ADDR_ALARM_IMG: prdata = alarm_pending_image;
      ADDR_CONFIG: prdata = {30'h0000_0000, lost_station_input_policy};
      ADDR_IRQ_STATUS: prdata = {28'h000_0000, irq_status};
      ADDR_IRQ_ENABLE: prdata = {28'h000_0000, irq_enable};
      ADDR_EVENT_LOG: prdata = {23'h00_0000, event_was_loss, event_station};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule

// file: test/group_control_props.sv
// Checker for the command word, send pulse and alarm service ports.
`timescale 1ns/1ns
module group_control_props
  import gcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic send_o,
  input wire logic [7:0] send_groups_o,
  input wire logic [6:0] send_cmd_o,
  input wire logic comm_request_i,
  input wire logic [7:0] comm_request_task_i,
  input wire logic [NUM_STATIONS-1:0] alarm_serviced_o
);
  logic [15:0] word_q;
  wire acc = psel && penable && pready;
  wire rd_acc = acc && !pwrite;
  wire cmd_wr = acc && pwrite && paddr == ADDR_GROUP_CMD;
  wire trig_go = cmd_wr && pwdata[TRIG_BIT] != word_q[TRIG_BIT];
  wire mapped = paddr[1:0] == 2'b00 && paddr <= ADDR_EVENT_LOG;
  wire ack_wr = acc && pwrite && paddr == ADDR_ALARM_ACK;
  wire svc = (comm_request_i && comm_request_task_i == 8'h09) || ack_wr;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_q <= 16'h0000;
    end else if (cmd_wr) begin
      word_q <= pwdata[15:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence toggle_s; trig_go; endsequence
  sequence pulse_s; ##2 send_o ##1 !send_o; endsequence
  send_after_a: assert property (toggle_s |-> pulse_s)
    else $error("no single send pulse after trigger toggle");
  send_fields_a: assert property (toggle_s |-> ##2
    send_groups_o == $past(pwdata[7:0], 2)
    && send_cmd_o == $past(pwdata[14:8], 2))
    else $error("send fields differ from written word");
  send_cause_a: assert property (send_o |-> $past(trig_go, 2))
    else $error("send pulse without trigger toggle");
  send_hold_a: assert property (!send_o
    |-> $stable({send_groups_o, send_cmd_o}))
    else $error("send fields moved without send");
  addr_err_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error wrong for address");
  word_read_a: assert property (rd_acc && paddr == ADDR_GROUP_CMD
    |-> prdata == {16'h0000, word_q})
    else $error("command word readback wrong");
  image_width_a: assert property (rd_acc && paddr == ADDR_ALARM_IMG
    |-> prdata[31:7] == 25'h0)
    else $error("alarm image upper bits set");
  serviced_one_a: assert property (alarm_serviced_o != '0
    |-> $onehot(alarm_serviced_o) && svc)
    else $error("alarm service without request or not single");
endmodule

// file: test/remote_stations.sv
// Model of the remote stations: alarms, link health, sync and freeze.
`timescale 1ns/1ns
module remote_stations
  import gcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [7:0] groups_i,
  input wire logic [6:0] cmd_i,
  input wire logic [NUM_STATIONS-1:0] serviced_i,
  output logic [NUM_STATIONS-1:0] alarm_o = '0,
  output logic [NUM_STATIONS-1:0] alive_o = '1,
  output logic [7:0] synced_o = 8'h00,
  output logic [7:0] frozen_o = 8'h00
);
  // A station keeps its alarm raised until the master services it.
  always @(posedge clk_i) begin
    if (serviced_i != '0) alarm_o <= alarm_o & ~serviced_i;
    if (send_i && cmd_i == CMD_SYNC) synced_o <= synced_o | groups_i;
    if (send_i && cmd_i == CMD_UNSYNC) synced_o <= synced_o & ~groups_i;
    if (send_i && cmd_i == CMD_FREEZE) frozen_o <= frozen_o | groups_i;
    if (send_i && cmd_i == CMD_UNFREEZE) frozen_o <= frozen_o & ~groups_i;
  end
  task raise(input int n);
    alarm_o[n] <= 1'b1;
  endtask
  task link(input int n, input logic v);
    alive_o[n] <= v;
  endtask
endmodule

// file: test/test_group_control.sv
// Self-checking bench for the group command and alarm block.
`timescale 1ns/1ns
module test_group_control;
  import gcw_pkg::*;
  logic clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, comm_request_task_i = '0, send_groups_o;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, send_o, irq_o, err;
  logic scan_start_i = 0, comm_request_i = 0;
  logic [6:0] send_cmd_o, data_station_i = 7'd3;
  logic [15:0] data_raw_i = 16'h1234, data_o;
  logic [NUM_STATIONS-1:0] alarm_pend_i, alarm_serviced_o, station_alive_i;
  logic [7:0] synced, frozen;
  logic [6:0] codes [4] = '{CMD_FREEZE, CMD_SYNC, CMD_UNFREEZE, CMD_UNSYNC};
  logic [7:0] masks [4] = '{8'h81, 8'h10, 8'h81, 8'hFF};
  int mismatches = 0, checks_done = 0;
  initial forever #20 clk_i = ~clk_i;
  group_control uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .send_o(send_o),
    .send_groups_o(send_groups_o), .send_cmd_o(send_cmd_o),
    .scan_start_i(scan_start_i), .alarm_pend_i(alarm_pend_i),
    .comm_request_i(comm_request_i),
    .comm_request_task_i(comm_request_task_i),
    .alarm_serviced_o(alarm_serviced_o), .station_alive_i(station_alive_i),
    .data_station_i(data_station_i), .data_raw_i(data_raw_i),
    .data_o(data_o), .irq_o(irq_o));
  remote_stations peer (.clk_i(clk_i), .send_i(send_o),
    .groups_i(send_groups_o), .cmd_i(send_cmd_o),
    .serviced_i(alarm_serviced_o), .alarm_o(alarm_pend_i),
    .alive_o(station_alive_i), .synced_o(synced), .frozen_o(frozen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // The request is held until pready is seen high, then released.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      final_report;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rdata, e);
  endtask
  task scan;
    scan_start_i <= 1;
    @(posedge clk_i);
    scan_start_i <= 0;
    comm_request_i <= 0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    rd(ADDR_CONFIG, {30'h0, CONFIG_RESET});
    rd(ADDR_GROUP_CMD, 32'h0);
    apb(1, ADDR_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_GROUP_CMD, {16'h0, ~i[0], codes[i], masks[i]});
      @(negedge clk_i);
      chk(send_o, 1);
      chk(send_groups_o, masks[i]);
      chk(send_cmd_o, codes[i]);
      @(negedge clk_i);
      chk(send_o, 0);
      chk(irq_o, 1);
      if (i == 1) chk({synced, frozen}, 16'h1081);
      @(posedge clk_i);
      apb(1, ADDR_IRQ_CLEAR, 32'h1);
      @(negedge clk_i);
      chk(irq_o, 0);
      @(posedge clk_i);
    end
    apb(1, ADDR_GROUP_CMD, {16'h0, 1'b0, CMD_SYNC, 8'h01});
    @(negedge clk_i);
    chk(send_o, 0);
    @(posedge clk_i);
    rd(ADDR_GROUP_CMD, 32'h2001);
    rd(8'h40, 32'h0);
    chk(err, 1);
    apb(1, ADDR_IRQ_ENABLE, 32'h0);
    apb(1, ADDR_GROUP_CMD, {16'h0, 1'b1, CMD_SYNC, 8'h01});
    apb(1, ADDR_GROUP_CMD, {16'h0, 1'b0, 7'h03, 8'h01});
    apb(0, ADDR_IRQ_STATUS, 32'h0);
    chk(rdata[IRQ_SENT], 1);
    chk(rdata[IRQ_BAD_CMD], 1);
    chk(irq_o, 0);
    peer.raise(9);
    peer.raise(5);
    scan;
    rd(ADDR_ALARM_IMG, 32'd5);
    scan;
    rd(ADDR_ALARM_IMG, 32'd5);
    comm_request_task_i <= 8'd9;
    comm_request_i <= 1;
    @(posedge clk_i);
    comm_request_i <= 0;
    scan;
    rd(ADDR_ALARM_IMG, 32'd9);
    apb(1, ADDR_ALARM_ACK, 32'h0);
    scan;
    rd(ADDR_ALARM_IMG, 32'h0);
    peer.raise(7);
    peer.raise(8);
    scan;
    rd(ADDR_ALARM_IMG, 32'd7);
    comm_request_i <= 1;
    scan;
    rd(ADDR_ALARM_IMG, 32'd8);
    chk(data_o, 16'h1234);
    peer.link(3, 1'b0);
    repeat (5) @(posedge clk_i);
    data_raw_i <= 16'h5678;
    repeat (3) @(posedge clk_i);
    chk(data_o, 16'h1234);
    rd(ADDR_EVENT_LOG, 32'h103);
    apb(1, ADDR_CONFIG, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(data_o, 16'h0);
    peer.link(3, 1'b1);
    repeat (6) @(posedge clk_i);
    chk(data_o, 16'h5678);
    rd(ADDR_EVENT_LOG, 32'h103);
    rd(ADDR_IRQ_STATUS, 32'hF);
    final_report;
  end
endmodule
bind group_control group_control_props props (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .send_o(send_o), .send_groups_o(send_groups_o),
  .send_cmd_o(send_cmd_o), .comm_request_i(comm_request_i),
  .comm_request_task_i(comm_request_task_i),
  .alarm_serviced_o(alarm_serviced_o));
